// ### core/rst_vec_pkg.sv
package rst_vec_pkg;
  // register byte offsets (chosen map)
  localparam logic [7:0] mcu_control_off = 8'h00;
  localparam logic [7:0] reset_status_off = 8'h04;
  localparam logic [7:0] vector_info_off = 8'h08;
  // mcu_control field positions
  localparam int unlock_bit = 0;
  localparam int select_bit = 1;
  localparam logic [7:0] mcu_control_reset = 8'h00;
  // unlock window length in clock cycles
  localparam logic [2:0] unlock_cycles = 3'h4;
  // vector word addresses
  localparam logic [15:0] app_reset_vec = 16'h0000;
  localparam logic [15:0] boot_reset_vec = 16'h1c00;
  localparam logic [15:0] app_irq_base = 16'h0002;
  localparam logic [15:0] boot_irq_base = 16'h1c02;
  // external pin minimum low pulse
  localparam int ext_min_ns = 2500;
  localparam int clk_ns = 25;
  localparam int ext_min_cycles = (ext_min_ns + clk_ns - 1) / clk_ns;
  // axi responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // delay counter base unit
  localparam int delay_unit_cycles = 64;
  localparam int delay_w = 20;
endpackage : rst_vec_pkg

// ### core/reset_and_vector_select.sv
// Function
// - while reset is asserted every software-visible register holds its initial value.
// - on release of reset the core fetches from the currently selected reset vector.
// - the port reset output goes active at once, without a clock, when any source is active.
// - after all sources go inactive, internal reset is held while a delay counter runs.
// - the delay length comes from the startup-time and clock-select fuses only.
// - there are exactly four reset sources and any one active asserts system reset.
// - a power-on detector report of supply below threshold asserts reset.
// - an external pin held low longer than the minimum pulse asserts reset.
// - watchdog expiry asserts reset only when watchdog system-reset mode is on.
// - brown-out asserts reset only when the brown-out detector is enabled.
// - the unlock bit clears four cycles after set or when select is written.
// - interrupts are blocked while the unlock window is open.
// - with boot-reset fuse programmed and select clear reset is 0x1c00 and vectors start at 0x0002.
// - with fuse unprogrammed and select set reset is 0x0000 and vectors at 0x1c02.
`timescale 1ns/100ps
module reset_and_vector_select
(
  // clock and bus reset
  input wire logic aclk,
  input wire logic aresetn,
  // reset sources
  input wire logic por_below_threshold,
  input wire logic ext_reset_n,
  input wire logic wdt_expired,
  input wire logic wdt_reset_mode,
  input wire logic bod_enable,
  input wire logic bod_below_threshold,
  // fuses
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_select_fuses,
  input wire logic boot_reset_fuse,
  // reset and vector outputs
  output logic port_reset,
  output logic core_reset,
  output logic [15:0] fetch_addr,
  output logic [15:0] irq_base,
  output logic irq_block,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // synchronisers for pin-level sources
  logic [4:0] src_meta_reg;
  logic [4:0] src_sync_reg;
  logic [4:0] src_raw;
  assign src_raw = {~ext_reset_n, por_below_threshold, wdt_expired,
                    bod_below_threshold, bod_enable};

  always_ff @(posedge aclk)
  begin
    src_meta_reg <= src_raw;
    src_sync_reg <= src_meta_reg;
  end

  // external pin must stay low for the minimum pulse before it counts
  logic [7:0] ext_cnt_reg;
  logic [7:0] ext_cnt_next;
  logic ext_long;
  assign ext_long = ext_cnt_reg >= 8'(rst_vec_pkg::ext_min_cycles);
  assign ext_cnt_next = !src_sync_reg[4] ? 8'h00 : (ext_long ? ext_cnt_reg : ext_cnt_reg + 8'h01);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_cnt_reg <= 8'h00;
    else
      ext_cnt_reg <= ext_cnt_next;
  end

  // the four sources; sync copies gate the clocked stretch
  logic [3:0] src_vec;
  logic any_src;
  assign src_vec[0] = src_sync_reg[3];
  assign src_vec[1] = ext_long;
  assign src_vec[2] = src_sync_reg[2] & wdt_reset_mode;
  assign src_vec[3] = src_sync_reg[1] & src_sync_reg[0];
  assign any_src = |src_vec;

  // raw combination drives the clockless port reset path
  logic async_src;
  assign async_src = por_below_threshold | ~ext_reset_n
                   | (wdt_expired & wdt_reset_mode)
                   | (bod_enable & bod_below_threshold);

  // port reset flop: asynchronous set from the raw sources, needs no clock
  always_ff @(posedge aclk or posedge async_src)
  begin
    if (async_src)
      port_reset <= 1'b1;
    else
      port_reset <= any_src | core_reset;
  end

  // delay length from fuses only; software has no say
  function automatic logic [rst_vec_pkg::delay_w-1:0] delay_len(input logic [1:0] st_fuse,
                                                               input logic [3:0] ck_fuse);
    delay_len = rst_vec_pkg::delay_w'((st_fuse + 2'h1) * (ck_fuse + 4'h1)
                                      * rst_vec_pkg::delay_unit_cycles);
  endfunction : delay_len

  logic [rst_vec_pkg::delay_w-1:0] delay_cnt_reg;
  logic [rst_vec_pkg::delay_w-1:0] delay_cnt_next;
  logic delay_done;
  assign delay_done = delay_cnt_reg == delay_len(startup_time_fuses, clock_select_fuses);
  assign delay_cnt_next = any_src ? '0
                        : (delay_done ? delay_cnt_reg
                        : delay_cnt_reg + rst_vec_pkg::delay_w'(1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      delay_cnt_reg <= '0;
      core_reset <= 1'b1;
    end
    else
    begin
      delay_cnt_reg <= delay_cnt_next;
      core_reset <= any_src | !delay_done;
    end
  end

  // vector control register
  logic unlock_reg;
  logic select_reg;
  logic [2:0] unlock_cnt_reg;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_unlock;
  logic wr_select;
  logic unlock_expire;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  assign wr_fire = aw_held_reg & w_held_reg & !s_axi_bvalid;
  assign wr_ctrl = wr_fire & (aw_addr_reg == rst_vec_pkg::mcu_control_off) & w_strb_reg[0];
  assign wr_unlock = wr_ctrl & w_data_reg[rst_vec_pkg::unlock_bit];
  assign wr_select = wr_ctrl & !w_data_reg[rst_vec_pkg::unlock_bit];
  assign unlock_expire = unlock_cnt_reg == rst_vec_pkg::unlock_cycles - 3'h1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || core_reset)
    begin
      unlock_reg <= rst_vec_pkg::mcu_control_reset[rst_vec_pkg::unlock_bit];
      select_reg <= rst_vec_pkg::mcu_control_reset[rst_vec_pkg::select_bit];
      unlock_cnt_reg <= 3'h0;
    end
    else if (wr_unlock)
    begin
      unlock_reg <= 1'b1;
      unlock_cnt_reg <= 3'h0;
    end
    else if (wr_select)
    begin
      if (unlock_reg)
        select_reg <= w_data_reg[rst_vec_pkg::select_bit];
      unlock_reg <= 1'b0;
    end
    else if (unlock_reg)
    begin
      unlock_cnt_reg <= unlock_cnt_reg + 3'h1;
      if (unlock_expire)
        unlock_reg <= 1'b0;
    end
  end

  // vector selection
  logic [15:0] reset_vec;
  logic [15:0] irq_vec;
  assign reset_vec = boot_reset_fuse ? rst_vec_pkg::boot_reset_vec
                   : rst_vec_pkg::app_reset_vec;
  assign irq_vec = select_reg ? rst_vec_pkg::boot_irq_base
                 : rst_vec_pkg::app_irq_base;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fetch_addr <= rst_vec_pkg::app_reset_vec;
      irq_base <= rst_vec_pkg::app_irq_base;
      irq_block <= 1'b1;
    end
    else
    begin
      fetch_addr <= reset_vec;
      irq_base <= irq_vec;
      irq_block <= core_reset | unlock_reg | wr_unlock;
    end
  end

  // axi write channel: capture address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rst_vec_pkg::resp_okay;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg == rst_vec_pkg::mcu_control_off)
                       ? rst_vec_pkg::resp_okay : rst_vec_pkg::resp_slverr;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // axi read channel
  logic [31:0] rd_word;
  logic rd_hit;
  assign rd_hit = s_axi_araddr == rst_vec_pkg::mcu_control_off
               || s_axi_araddr == rst_vec_pkg::reset_status_off
               || s_axi_araddr == rst_vec_pkg::vector_info_off;
  assign rd_word = (s_axi_araddr == rst_vec_pkg::mcu_control_off)
                   ? {30'h0, select_reg, unlock_reg}
                 : (s_axi_araddr == rst_vec_pkg::reset_status_off)
                   ? {27'h0, core_reset, src_vec}
                 : (s_axi_araddr == rst_vec_pkg::vector_info_off)
                   ? {irq_vec, reset_vec}
                 : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rst_vec_pkg::resp_okay;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? rst_vec_pkg::resp_okay : rst_vec_pkg::resp_slverr;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  a_unlock_four_cycles: assert property (@(posedge aclk) disable iff (!aresetn || core_reset)
    $rose(unlock_reg) && !wr_select [*1] |-> ##[0:4] !unlock_reg)
    else $error("unlock bit outlived its window");
  a_select_clears_unlock: assert property (@(posedge aclk) disable iff (!aresetn || core_reset)
    wr_select |=> !unlock_reg)
    else $error("select write did not clear unlock");
  a_locked_select_kept: assert property (@(posedge aclk) disable iff (!aresetn || core_reset)
    wr_select && !unlock_reg |=> $stable(select_reg))
    else $error("select changed without unlock");
  a_irq_blocked_open: assert property (@(posedge aclk) disable iff (!aresetn)
    unlock_reg |=> irq_block)
    else $error("interrupts open during unlock window");
  a_src_holds_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    any_src |=> core_reset && delay_cnt_reg == '0)
    else $error("source did not restart delay");
  a_release_at_done: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(core_reset) |-> $past(delay_done) && !$past(any_src))
    else $error("reset released before delay end");
  a_bod_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !src_sync_reg[0] |-> !src_vec[3])
    else $error("disabled brown-out caused reset");
  a_wdt_mode_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !wdt_reset_mode |-> !src_vec[2])
    else $error("watchdog reset without mode");
  a_fetch_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (fetch_addr == (boot_reset_fuse ? rst_vec_pkg::boot_reset_vec
                        : rst_vec_pkg::app_reset_vec)) or $changed(boot_reset_fuse))
    else $error("fetch address does not match fuse");
  a_reg_init_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    core_reset |=> !unlock_reg && !select_reg)
    else $error("control not at initial value in reset");
  a_port_reset_src: assert property (@(posedge aclk) disable iff (!aresetn)
    async_src |-> port_reset)
    else $error("port reset missing with source active");

endmodule : reset_and_vector_select

// ### dv/source_model.sv
`timescale 1ns/100ps
module source_model
(
  // clock
  input wire logic aclk,
  // reset sources
  output logic por_below_threshold,
  output logic ext_reset_n,
  output logic wdt_expired,
  output logic wdt_reset_mode,
  output logic bod_enable,
  output logic bod_below_threshold
);
  initial
  begin
    por_below_threshold = 1'h0;
    ext_reset_n = 1'h1;
    wdt_expired = 1'h0;
    wdt_reset_mode = 1'h1;
    bod_enable = 1'h1;
    bod_below_threshold = 1'h0;
  end
  // src: 0 power-on, 1 pin, 2 watchdog, 3 brown-out; call just after an edge
  task automatic drive(input int src, input logic on);
    case (src)
      0: por_below_threshold <= on;
      1: ext_reset_n <= !on;
      2: wdt_expired <= on;
      default: bod_below_threshold <= on;
    endcase
  endtask : drive
  task automatic set_modes(input logic wdt_mode, input logic bod_on);
    wdt_reset_mode <= wdt_mode;
    bod_enable <= bod_on;
  endtask : set_modes
  // a pin pulse shorter than the minimum would be filtered, so it is stretched
  task automatic hold(input int src, input int cycles);
    drive(src, 1'h1);
    repeat ((src == 1 && cycles <= rst_vec_pkg::ext_min_cycles) ?
            rst_vec_pkg::ext_min_cycles + 1 : cycles) @(posedge aclk);
    drive(src, 1'h0);
  endtask : hold
endmodule : source_model

// ### dv/reset_and_vector_select_bench.sv
`timescale 1ns/100ps
module reset_and_vector_select_bench;
  logic aclk, aresetn, boot_reset_fuse, port_reset, core_reset, irq_block;
  logic por_below_threshold, ext_reset_n, wdt_expired, wdt_reset_mode;
  logic bod_enable, bod_below_threshold;
  logic [1:0] startup_time_fuses, s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] clock_select_fuses, s_axi_wstrb;
  logic [15:0] fetch_addr, irq_base;
  logic [7:0] s_axi_awaddr, s_axi_araddr, a;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  reset_and_vector_select u_dut (.aclk, .aresetn, .por_below_threshold, .ext_reset_n,
    .wdt_expired, .wdt_reset_mode, .bod_enable, .bod_below_threshold, .startup_time_fuses,
    .clock_select_fuses, .boot_reset_fuse, .port_reset, .core_reset, .fetch_addr, .irq_base,
    .irq_block, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  source_model u_src (.aclk, .por_below_threshold, .ext_reset_n, .wdt_expired,
    .wdt_reset_mode, .bod_enable, .bod_below_threshold);
  initial
  begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %0t bus response %h exp %h", $time, got, exp);
    end
  endtask : chk_resp
  // ready lines stay high, so each response is taken at the edge it first shows
  task automatic axi_write(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_read
  function automatic int exp_delay();
    return (int'(startup_time_fuses) + 1) * (int'(clock_select_fuses) + 1) *
      rst_vec_pkg::delay_unit_cycles;
  endfunction : exp_delay
  // slack above the count covers the source synchronisers
  task automatic wait_release();
    int n;
    n = 0;
    while (core_reset !== 1'h0 && n < 5000)
    begin
      @(posedge aclk);
      n++;
    end
    chk(n >= exp_delay() && n <= exp_delay() + 8, 1, "delay length");
    @(posedge aclk);
    #1;
    chk(port_reset, 0, "port reset idle");
    chk(fetch_addr, boot_reset_fuse ? 16'h1c00 : 16'h0000, "reset vector");
    @(posedge aclk);
  endtask : wait_release
  initial
  begin
    rd = $urandom(43273);
    aresetn = 1'h0;
    startup_time_fuses = 2'($urandom % 2);
    clock_select_fuses = 4'($urandom % 4);
    boot_reset_fuse = 1'($urandom);
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    repeat (20) @(posedge aclk);
    #1;
    chk({core_reset, irq_block, irq_base}, 18'h30002, "held in reset");
    @(posedge aclk);
    aresetn <= 1'h1;
    wait_release();
    for (int s = 0; s < 4; s++)
    begin
      u_src.drive(s, 1'h1);
      #1;
      chk(port_reset, 1, "port reset async");
      repeat (121) @(posedge aclk);
      u_src.drive(s, 1'h0);
      repeat (exp_delay() / 2) @(posedge aclk);
      chk(core_reset, 1, "stretch");
      u_src.hold(s, 120);
      wait_release();
    end
    u_src.set_modes(1'h0, 1'h0);
    u_src.hold(2, 10);
    u_src.hold(3, 10);
    repeat (4) @(posedge aclk);
    chk({core_reset, port_reset}, 0, "disabled sources");
    u_src.drive(1, 1'h1);
    repeat (50) @(posedge aclk);
    chk({core_reset, port_reset}, 1, "short pin pulse");
    u_src.drive(1, 1'h0);
    repeat (4) @(posedge aclk);
    chk(core_reset, 0, "short pulse filtered");
    u_src.set_modes(1'h1, 1'h1);
    axi_read(rst_vec_pkg::reset_status_off, rd, rs);
    chk(rd[4:0], 0, "status idle");
    axi_write(rst_vec_pkg::mcu_control_off, 32'h2, rs);
    chk_resp(rs, rst_vec_pkg::resp_okay);
    axi_read(rst_vec_pkg::mcu_control_off, rd, rs);
    chk(rd[1:0], 0, "locked select");
    axi_write(rst_vec_pkg::mcu_control_off, 32'h1, rs);
    axi_write(rst_vec_pkg::mcu_control_off, 32'h2, rs);
    axi_read(rst_vec_pkg::mcu_control_off, rd, rs);
    chk(rd[1:0], 2, "unlocked select");
    axi_read(rst_vec_pkg::vector_info_off, rd, rs);
    chk(rd, {16'h1c02, boot_reset_fuse ? 16'h1c00 : 16'h0000}, "vector info");
    chk(irq_base, 16'h1c02, "irq base moved");
    axi_write(rst_vec_pkg::mcu_control_off, 32'h1, rs);
    @(posedge aclk);
    #1;
    chk(irq_block, 1, "window blocks");
    @(posedge aclk);
    repeat (6) @(posedge aclk);
    axi_write(rst_vec_pkg::mcu_control_off, 32'h0, rs);
    axi_read(rst_vec_pkg::mcu_control_off, rd, rs);
    chk({irq_block, rd[1:0]}, 2, "window expiry");
    for (int i = 0; i < 8; i++)
    begin
      a = 8'h0c + 8'(($urandom % 61) * 4);
      axi_read(a, rd, rs);
      chk_resp(rs, rst_vec_pkg::resp_slverr);
      chk(rd, 0, "unmapped read");
      axi_write(a, $urandom, rs);
      chk_resp(rs, rst_vec_pkg::resp_slverr);
    end
    u_src.hold(0, 20);
    wait_release();
    axi_read(rst_vec_pkg::mcu_control_off, rd, rs);
    chk({irq_base, rd[1:0]}, 18'h00008, "registers cleared");
    conclude();
  end
endmodule : reset_and_vector_select_bench
